/* File: src/ctm_core.sv */
// Compact 10-bit timer with AXI4-Lite register access
// Overview of operation
// [R1] Each route bit set hands its pin to the timer, else pin keeps other use.
// [R2] Compare low write fills a buffer; high write loads high byte plus buffer.
// [R3] High byte read returns high bits and latches low byte into the buffer.
// [R4] Software writes low then high, reads high then low; other orders undefined.
// [R5] Counter and compare split into low byte bits 7-0, high byte bits 9-8.
// [R6] Core is a 10-bit up-counter on the selected clock source.
// [R7] Comparator P checks counter top three bits; comparator A all ten.
// [R8] Software cannot load the counter; its only software clear is a timer_on rise.
// [R9] Counter auto-clears on overflow or selected match; events raise interrupts.
// [R10] Pause bit holds the counter value; clearing it resumes from there.
// [R11] Clock select picks sys/4, sys, high/16, high/64, time base, pin edges.
// [R12] Counter pair is read-only; compare pair is read and write.
// [R13] Two output pins carry timer signal, each inverted by a port data bit.
// [R14] timer_on enables counting, off keeps value, rising edge clears counter.
// [R15] Period field matches at multiples of 128; zero means overflow at 1024.
// [R16] Clear select: one clears on A match, zero on P match or overflow.
// [R17] Counter steps once per enabled tick; pin edges sampled on system clock.
`timescale 1ns/1ns
module ctm_core #(
  parameter int CNT_WIDTH = ctm_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire ctm_pkg::ctm_axi_req_t axi_req,
  output ctm_pkg::ctm_axi_rsp_t axi_rsp,
  input wire logic high_clk_tick,
  input wire logic time_base_clock,
  input wire logic ext_count_input,
  input wire logic [1:0] port_data,
  output logic [ctm_pkg::ROUTE_W-1:0] pin_route,
  output ctm_pkg::ctm_pins_t pins,
  output logic irq
);
  import ctm_pkg::*;

  // Bus slave state
  logic aw_held_q, w_held_q, bvalid_q, awready_q, wready_q, arready_q;
  logic rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  // Registers and timer state
  logic [ROUTE_W-1:0] route_q;
  logic [7:0] ctl0_q, ctl1_q;
  logic [CNT_WIDTH-1:0] cnt_q, cmp_q;
  logic [7:0] cnt_buf_q, cmp_buf_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic irq_q, tm_q, ext_q;
  logic [1:0] sys_div_q;
  logic [5:0] hi_div_q;
  ctm_pins_t pins_q;

  // Write channel decode
  wire aw_fire = axi_req.awvalid & awready_q;
  wire w_fire = axi_req.wvalid & wready_q;
  wire wr_do = ce & aw_held_q & w_held_q & ~bvalid_q;
  wire [7:0] wa = {aw_addr_q[7:2], 2'h0};
  wire wb0 = w_strb_q[0];
  wire wa_route = (wa == OFF_ROUTE);
  wire wa_ctl0 = (wa == OFF_CTL0);
  wire wa_ctl1 = (wa == OFF_CTL1);
  wire wa_cnt = (wa == OFF_CNT_LO) | (wa == OFF_CNT_HI); // [R12]
  wire wa_cmp_lo = (wa == OFF_CMP_LO);
  wire wa_cmp_hi = (wa == OFF_CMP_HI);
  wire wa_stat = (wa == OFF_IRQ_STAT);
  wire wa_mask = (wa == OFF_IRQ_MASK);
  wire wa_ok = wa_route | wa_ctl0 | wa_ctl1 | wa_cnt | wa_cmp_lo |
               wa_cmp_hi | wa_stat | wa_mask;
  wire wr_route = wr_do & wb0 & wa_route;
  wire wr_ctl0 = wr_do & wb0 & wa_ctl0;
  wire wr_ctl1 = wr_do & wb0 & wa_ctl1;
  wire wr_cmp_lo = wr_do & wb0 & wa_cmp_lo;
  wire wr_cmp_hi = wr_do & wb0 & wa_cmp_hi;
  wire wr_stat = wr_do & wb0 & wa_stat;
  wire wr_mask = wr_do & wb0 & wa_mask;

  // Read channel decode
  wire ar_fire = ce & axi_req.arvalid & arready_q;
  wire [7:0] ra = {axi_req.araddr[7:2], 2'h0};
  wire ra_route = (ra == OFF_ROUTE);
  wire ra_ctl0 = (ra == OFF_CTL0);
  wire ra_ctl1 = (ra == OFF_CTL1);
  wire ra_cnt_lo = (ra == OFF_CNT_LO);
  wire ra_cnt_hi = (ra == OFF_CNT_HI);
  wire ra_cmp_lo = (ra == OFF_CMP_LO);
  wire ra_cmp_hi = (ra == OFF_CMP_HI);
  wire ra_stat = (ra == OFF_IRQ_STAT);
  wire ra_mask = (ra == OFF_IRQ_MASK);
  wire rd_cnt_hi = ar_fire & ra_cnt_hi;
  wire rd_cmp_hi = ar_fire & ra_cmp_hi;
  wire [7:0] rd_byte;
  wire rd_ok;

  // Registers sit in the low byte lane, upper lanes read zero
  assign rd_byte =
    ra_route ? {3'h0, route_q} :
    ra_ctl0 ? ctl0_q :
    ra_ctl1 ? ctl1_q :
    ra_cnt_lo ? cnt_buf_q : // [R3] [R5]
    ra_cnt_hi ? {6'h00, cnt_q[9:8]} : // [R3] [R5]
    ra_cmp_lo ? cmp_buf_q : // [R3]
    ra_cmp_hi ? {6'h00, cmp_q[9:8]} : // [R3] [R5]
    ra_stat ? {6'h00, stat_q} :
    ra_mask ? {6'h00, mask_q} :
    8'h00;
  assign rd_ok = ra_route | ra_ctl0 | ra_ctl1 | ra_cnt_lo | ra_cnt_hi |
                 ra_cmp_lo | ra_cmp_hi | ra_stat | ra_mask;

  // Control fields
  wire pause = ctl0_q[CTL0_PAUSE_BIT];
  wire timer_on = ctl0_q[CTL0_ON_BIT];
  wire [2:0] cksel = ctl0_q[CTL0_CKSEL_LSB +: 3];
  wire [2:0] period_field = ctl0_q[CTL0_PER_LSB +: PER_W];
  wire clear_source_select = ctl1_q[CTL1_CCLR_BIT];
  wire on_rise = wr_ctl0 & w_data_q[CTL0_ON_BIT] & ~timer_on; // [R14] [R8]

  // Clock source ticks
  wire sys4_tick = (sys_div_q == 2'(SYS_DIV - 1));
  wire hi16_tick = high_clk_tick & (hi_div_q[3:0] == 4'(HI_DIV_A - 1));
  wire hi64_tick = high_clk_tick & (hi_div_q == 6'(HI_DIV_B - 1));
  wire ext_rise = ext_count_input & ~ext_q; // [R17]
  wire ext_fall = ~ext_count_input & ext_q; // [R17]
  wire src_tick;
  // [R11]
  assign src_tick =
    (cksel == CK_SYS_DIV4) ? sys4_tick :
    (cksel == CK_SYS) ? 1'b1 :
    (cksel == CK_HI_DIV16) ? hi16_tick :
    (cksel == CK_HI_DIV64) ? hi64_tick :
    (cksel == CK_TBC_A) ? time_base_clock :
    (cksel == CK_TBC_B) ? time_base_clock :
    (cksel == CK_EXT_RISE) ? ext_rise :
    ext_fall;

  // Counter and comparators
  wire adv = ce & timer_on & ~pause & src_tick; // [R6] [R10] [R14] [R17]
  wire [CNT_WIDTH-1:0] cnt_inc = cnt_q + 10'h001;
  wire ovf = (cnt_q == 10'h3FF);
  wire hit_a = (cnt_inc == cmp_q); // [R7]
  wire hit_p = (period_field != 3'h0) ?
               ((cnt_inc[9:7] == period_field) && (cnt_inc[6:0] == 7'h00)) :
               ovf; // [R7] [R15]
  wire clr = clear_source_select ? hit_a : hit_p; // [R16]
  wire [IRQ_W-1:0] events = {adv & hit_p, adv & hit_a}; // [R9]
  wire [CNT_WIDTH-1:0] cnt_d =
    on_rise ? 10'h000 :
    adv ? (clr ? 10'h000 : cnt_inc) :
    cnt_q; // [R8] [R9] [R6]
  wire [IRQ_W-1:0] stat_d =
    (stat_q & ~(wr_stat ? w_data_q[IRQ_W-1:0] : 2'h0)) | events;
  wire [IRQ_W-1:0] mask_d = wr_mask ? w_data_q[IRQ_W-1:0] : mask_q;
  // Timer output toggles on each comparator A match, restarts low on enable
  wire tm_d = on_rise ? 1'b0 : (adv & hit_a) ? ~tm_q : tm_q;
  wire [ROUTE_W-1:0] route_d = wr_route ? w_data_q[ROUTE_W-1:0] : route_q;
  ctm_pins_t pins_d;
  assign pins_d.out_a = tm_d ^ port_data[0]; // [R13]
  assign pins_d.out_b = tm_d ^ port_data[1]; // [R13]
  assign pins_d.out_a_oe = route_d[0]; // [R1]
  assign pins_d.out_b_oe = route_d[1]; // [R1]

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (aw_fire) aw_addr_q <= axi_req.awaddr;
      if (w_fire) w_data_q <= axi_req.wdata;
      if (w_fire) w_strb_q <= axi_req.wstrb;
      aw_held_q <= (aw_held_q | aw_fire) & ~wr_do;
      w_held_q <= (w_held_q | w_fire) & ~wr_do;
    end
  end

  // Write response and channel readiness
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else if (ce) begin
      bvalid_q <= wr_do | (bvalid_q & ~axi_req.bready);
      if (wr_do) bresp_q <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      awready_q <= ~(aw_held_q | aw_fire) | wr_do;
      wready_q <= ~(w_held_q | w_fire) | wr_do;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      rvalid_q <= ar_fire | (rvalid_q & ~axi_req.rready);
      arready_q <= ~(ar_fire | (rvalid_q & ~axi_req.rready));
      if (ar_fire) rdata_q <= {24'h00_0000, rd_byte};
      if (ar_fire) rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Software registers; the counter pair takes no writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= ROUTE_RST;
      ctl0_q <= CTL0_RST;
      ctl1_q <= CTL1_RST;
      cmp_q <= CMP_RST;
      mask_q <= 2'h0;
    end else if (ce) begin
      route_q <= route_d; // [R1]
      if (wr_ctl0) ctl0_q <= w_data_q[7:0];
      if (wr_ctl1) ctl1_q <= w_data_q[7:0];
      if (wr_cmp_hi) cmp_q <= {w_data_q[1:0], cmp_buf_q}; // [R2] [R12]
      mask_q <= mask_d;
    end
  end

  // Low byte holding buffers; a write to the buffer beats a read capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_buf_q <= 8'h00;
      cmp_buf_q <= 8'h00;
    end else if (ce) begin
      if (rd_cnt_hi) cnt_buf_q <= cnt_q[7:0]; // [R3]
      if (wr_cmp_lo) begin
        cmp_buf_q <= w_data_q[7:0]; // [R2]
      end else if (rd_cmp_hi) begin
        cmp_buf_q <= cmp_q[7:0]; // [R3]
      end
    end
  end

  // Counter, prescalers and pin edge sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 10'h000;
      sys_div_q <= 2'h0;
      hi_div_q <= 6'h00;
      ext_q <= 1'b0;
      tm_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d; // [R6]
      sys_div_q <= sys_div_q + 2'h1;
      if (high_clk_tick) hi_div_q <= hi_div_q + 6'h01;
      ext_q <= ext_count_input; // [R17]
      tm_q <= tm_d;
    end
  end

  // Interrupt status and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'h0;
      irq_q <= 1'b0;
      pins_q.out_a <= 1'b0;
      pins_q.out_a_oe <= ROUTE_RST[0]; // [R1]
      pins_q.out_b <= 1'b0;
      pins_q.out_b_oe <= ROUTE_RST[1]; // [R1]
    end else if (ce) begin
      stat_q <= stat_d; // [R9]
      irq_q <= |(stat_d & mask_d);
      pins_q <= pins_d;
    end
  end

  assign axi_rsp.awready = awready_q;
  assign axi_rsp.wready = wready_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = arready_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign pin_route = route_q;
  assign pins = pins_q;
  assign irq = irq_q;

  // Checks
  sequence cmp_lo_wr_s;
    wr_cmp_lo;
  endsequence
  sequence cmp_hi_wr_s;
    wr_cmp_hi;
  endsequence
  sequence cnt_hi_rd_s;
    rd_cnt_hi;
  endsequence

  property cmp_pair_p;
    @(posedge aclk) disable iff (!aresetn)
    cmp_hi_wr_s |=> (cmp_q == {$past(w_data_q[1:0]), $past(cmp_buf_q)});
  endproperty
  cmp_pair_load_a: assert property (cmp_pair_p) // [R2]
    else $error("compare high write did not merge buffer");

  cmp_lo_only_a: assert property ( // [R2]
    @(posedge aclk) disable iff (!aresetn)
    cmp_lo_wr_s |=> $stable(cmp_q) && (cmp_buf_q == $past(w_data_q[7:0])))
    else $error("compare low write touched compare value");

  cnt_capture_a: assert property ( // [R3]
    @(posedge aclk) disable iff (!aresetn)
    cnt_hi_rd_s |=> (cnt_buf_q == $past(cnt_q[7:0])) &&
      (rdata_q[1:0] == $past(cnt_q[9:8])) && (rdata_q[31:2] == 30'h0))
    else $error("counter high read failed to capture low byte");

  cnt_no_load_a: assert property ( // [R8]
    @(posedge aclk) disable iff (!aresetn)
    !(adv || on_rise) |=> $stable(cnt_q))
    else $error("counter changed without tick or enable rise");

  on_rise_clr_a: assert property ( // [R14]
    @(posedge aclk) disable iff (!aresetn)
    on_rise |=> (cnt_q == 10'h000) ##1 (timer_on == 1'b1))
    else $error("timer enable rise did not clear counter");

  pause_hold_a: assert property ( // [R10]
    @(posedge aclk) disable iff (!aresetn)
    (pause && !on_rise) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved while paused");

  period_clr_a: assert property ( // [R16]
    @(posedge aclk) disable iff (!aresetn)
    (adv && !clear_source_select && hit_p && !on_rise) |=>
      (cnt_q == 10'h000) && stat_q[IRQ_MATCH_P_BIT])
    else $error("period match did not clear and flag");

  a_match_clr_a: assert property ( // [R16]
    @(posedge aclk) disable iff (!aresetn)
    (adv && clear_source_select && hit_a && !on_rise) |=>
      (cnt_q == 10'h000) && stat_q[IRQ_MATCH_A_BIT])
    else $error("compare A match did not clear and flag");

  step_one_a: assert property ( // [R17]
    @(posedge aclk) disable iff (!aresetn)
    (adv && !clr && !on_rise) |=> (cnt_q == $past(cnt_q) + 10'h001))
    else $error("counter did not step by one");

  irq_level_a: assert property ( // [R9]
    @(posedge aclk) disable iff (!aresetn)
    irq == |(stat_q & mask_q))
    else $error("interrupt level disagrees with status and mask");

  pin_route_a: assert property ( // [R1]
    @(posedge aclk) disable iff (!aresetn)
    (pins.out_a_oe == pin_route[0]) && (pins.out_b_oe == pin_route[1]))
    else $error("pin enable does not follow route bit");

  out_invert_a: assert property ( // [R13]
    @(posedge aclk) disable iff (!aresetn)
    ce |=> (pins.out_a ^ pins.out_b) == ^$past(port_data))
    else $error("output pair inversion wrong");

  out_toggle_a: assert property ( // [R13]
    @(posedge aclk) disable iff (!aresetn)
    (adv && hit_a && !on_rise) |=> (tm_q != $past(tm_q)))
    else $error("timer output did not toggle on match");

  stat_sticky_a: assert property ( // [R9]
    @(posedge aclk) disable iff (!aresetn)
    (stat_q[IRQ_MATCH_A_BIT] && !(wr_stat && w_data_q[IRQ_MATCH_A_BIT])) |=>
      stat_q[IRQ_MATCH_A_BIT])
    else $error("match A status lost without clear");

  rd_answer_a: assert property ( // [R12]
    @(posedge aclk) disable iff (!aresetn)
    ar_fire |=> rvalid_q ##0 !arready_q)
    else $error("read not answered next cycle");
endmodule // ctm_core

/* File: src/ctm_pkg.sv */
// Shared constants and carrier types for the compact timer core
package ctm_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int CNT_W = 10;
  localparam int PER_W = 3;
  localparam int ROUTE_W = 5;
  localparam int IRQ_W = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_ROUTE = 8'h00;
  localparam logic [7:0] OFF_CTL0 = 8'h04;
  localparam logic [7:0] OFF_CTL1 = 8'h08;
  localparam logic [7:0] OFF_CNT_LO = 8'h0C;
  localparam logic [7:0] OFF_CNT_HI = 8'h10;
  localparam logic [7:0] OFF_CMP_LO = 8'h14;
  localparam logic [7:0] OFF_CMP_HI = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // Field positions in timer_control_0 and timer_control_1
  localparam int CTL0_PAUSE_BIT = 7;
  localparam int CTL0_CKSEL_LSB = 4;
  localparam int CTL0_ON_BIT = 3;
  localparam int CTL0_PER_LSB = 0;
  localparam int CTL1_CCLR_BIT = 0;
  // Interrupt status layout
  localparam int IRQ_MATCH_A_BIT = 0;
  localparam int IRQ_MATCH_P_BIT = 1;

  // Reset values
  localparam logic [4:0] ROUTE_RST = 5'h05;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;

  // Prescaler divide counts
  localparam int SYS_DIV = 4;
  localparam int HI_DIV_A = 16;
  localparam int HI_DIV_B = 64;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0,
    CK_SYS = 3'h1,
    CK_HI_DIV16 = 3'h2,
    CK_HI_DIV64 = 3'h3,
    CK_TBC_A = 3'h4,
    CK_TBC_B = 3'h5,
    CK_EXT_RISE = 3'h6,
    CK_EXT_FALL = 3'h7
  } ctm_cksel_t;

  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } ctm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ctm_axi_rsp_t;

  typedef struct packed {
    logic out_a;
    logic out_a_oe;
    logic out_b;
    logic out_b_oe;
  } ctm_pins_t;
endpackage

/* File: bench/tb_ctm_core.sv */
// Self-checking testbench for the compact timer core
`timescale 1ns/1ns
`define CHK_EQ(what, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); \
  end \
end

module tb_ctm_core;
  import ctm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  ctm_axi_req_t req = '0;
  ctm_axi_rsp_t rsp;
  logic hck = 1'b0;
  logic tbc = 1'b0;
  logic ext = 1'b0;
  logic [1:0] port_data = 2'h0;
  logic [ROUTE_W-1:0] pin_route;
  ctm_pins_t pins;
  logic irq;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [9:0] cv;
  logic [9:0] held;

  always #10 aclk = ~aclk;

  ctm_core #(.CNT_WIDTH(CNT_W)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .axi_req(req), .axi_rsp(rsp), .high_clk_tick(hck),
    .time_base_clock(tbc), .ext_count_input(ext), .port_data(port_data),
    .pin_route(pin_route), .pins(pins), .irq(irq));

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write with address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid === 1'b1) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 100) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_done;
    ar_done = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (!ar_done && rsp.arready === 1'b1) begin
        ar_done = 1'b1;
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid === 1'b1) begin
        rv = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 100) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // High byte first so the low byte comes from the captured buffer
  task automatic rd_cnt();
    rd(OFF_CNT_HI);
    cv[9:8] = rv[1:0];
    rd(OFF_CNT_LO);
    cv[7:0] = rv[7:0];
  endtask

  function automatic logic [31:0] ctl0(input logic p, input logic [2:0] s,
                                       input logic on, input logic [2:0] per);
    return {24'h000000, p, s, on, per};
  endfunction

  task automatic start_timer(input logic [2:0] s, input logic [2:0] per);
    wr(OFF_CTL0, ctl0(1'b0, s, 1'b0, per));
    wr(OFF_CTL0, ctl0(1'b0, s, 1'b1, per));
  endtask

  // Each pulse is one input tick for the given select; selects 2 and 3 count once per 16 or 64 of them
  task automatic pulses(input logic [2:0] s, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (s >= 3'h6) ext <= 1'b1;
      else if (s >= 3'h4) tbc <= 1'b1;
      else hck <= 1'b1;
      @(posedge aclk);
      ext <= 1'b0;
      tbc <= 1'b0;
      hck <= 1'b0;
    end
    tick(4);
  endtask

  task automatic t_reset_and_route();
    `CHK_EQ("route pins", ROUTE_RST, pin_route)
    `CHK_EQ("oe a", 1'b1, pins.out_a_oe)
    `CHK_EQ("oe b", 1'b0, pins.out_b_oe)
    rd(OFF_ROUTE);
    `CHK_EQ("route reg", 32'h00000005, rv)
    wr(OFF_ROUTE, 32'h0000001F);
    `CHK_EQ("route all", 5'h1F, pin_route)
    `CHK_EQ("oe b on", 1'b1, pins.out_b_oe)
    wr(OFF_ROUTE, 32'h00000000);
    tick(1);
    `CHK_EQ("oe a off", 1'b0, pins.out_a_oe)
    wr(OFF_ROUTE, 32'h00000003);
    `CHK_EQ("write resp", RESP_OKAY, rs)
    wr(8'h24, 32'h000000FF);
    `CHK_EQ("unmapped write resp", RESP_SLVERR, rs)
    rd(8'h24);
    `CHK_EQ("unmapped resp", RESP_SLVERR, rs)
    `CHK_EQ("unmapped data", 32'h00000000, rv)
  endtask

  task automatic t_cmp_buffer();
    wr(OFF_CMP_LO, 32'h000000AB);
    rd(OFF_CMP_HI);
    rd(OFF_CMP_LO);
    `CHK_EQ("low write held", 32'h00000000, rv)
    wr(OFF_CMP_LO, 32'h000000AB);
    wr(OFF_CMP_HI, 32'h00000002);
    rd(OFF_CMP_HI);
    `CHK_EQ("cmp high", 32'h00000002, rv)
    rd(OFF_CMP_LO);
    `CHK_EQ("cmp low", 32'h000000AB, rv)
  endtask

  task automatic t_sources();
    logic [2:0] sel [6] = '{3'h6, 3'h7, 3'h4, 3'h5, 3'h2, 3'h3};
    int np [6] = '{3, 3, 3, 3, 32, 128};
    logic [9:0] ex [6] = '{10'h003, 10'h003, 10'h003, 10'h003, 10'h002,
                           10'h002};
    for (int i = 0; i < 6; i++) begin
      start_timer(sel[i], 3'h0);
      pulses(sel[i], np[i]);
      rd_cnt();
      `CHK_EQ("count per source", ex[i], cv)
    end
    // Free divider phase is unknown, so 42 counted edges give 10 or 11
    start_timer(3'h0, 3'h0);
    tick(40);
    rd_cnt();
    `CHK_EQ("count sys/4", 1'b1, cv >= 10'h00A && cv <= 10'h00B)
  endtask

  task automatic t_pause_on();
    start_timer(3'h1, 3'h0);
    wr(OFF_CTL0, ctl0(1'b1, 3'h1, 1'b1, 3'h0));
    rd_cnt();
    held = cv;
    tick(10);
    rd_cnt();
    `CHK_EQ("paused hold", held, cv)
    `CHK_EQ("ran before pause", 1'b1, held != 10'h000)
    wr(OFF_CTL0, ctl0(1'b0, 3'h1, 1'b1, 3'h0));
    wr(OFF_CTL0, ctl0(1'b1, 3'h1, 1'b1, 3'h0));
    rd_cnt();
    `CHK_EQ("resumed", 1'b1, cv > held)
    held = cv;
    wr(OFF_CNT_LO, 32'h000000FF);
    wr(OFF_CNT_HI, 32'h00000003);
    `CHK_EQ("count write resp", RESP_OKAY, rs)
    rd_cnt();
    `CHK_EQ("no software load", held, cv)
    start_timer(3'h6, 3'h0);
    pulses(3'h6, 2);
    wr(OFF_CTL0, ctl0(1'b0, 3'h6, 1'b0, 3'h0));
    pulses(3'h6, 3);
    rd_cnt();
    `CHK_EQ("off retains", 10'h002, cv)
    wr(OFF_CTL0, ctl0(1'b0, 3'h6, 1'b1, 3'h0));
    rd_cnt();
    `CHK_EQ("on rise clears", 10'h000, cv)
  endtask

  task automatic t_match_a();
    wr(OFF_CMP_LO, 32'h00000005);
    wr(OFF_CMP_HI, 32'h00000000);
    wr(OFF_CTL1, 32'h00000001);
    wr(OFF_IRQ_MASK, 32'h00000001);
    start_timer(3'h6, 3'h0);
    wr(OFF_IRQ_STAT, 32'h00000003);
    pulses(3'h6, 4);
    `CHK_EQ("irq before match", 1'b0, irq)
    pulses(3'h6, 1);
    rd_cnt();
    `CHK_EQ("cleared on A", 10'h000, cv)
    `CHK_EQ("irq on A", 1'b1, irq)
    `CHK_EQ("out a toggled", 1'b1, pins.out_a)
    @(posedge aclk);
    port_data <= 2'h3;
    tick(3);
    `CHK_EQ("out a inverted", 1'b0, pins.out_a)
    `CHK_EQ("out b inverted", 1'b0, pins.out_b)
    @(posedge aclk);
    port_data <= 2'h0;
    wr(OFF_IRQ_STAT, 32'h00000001);
    tick(1);
    `CHK_EQ("irq cleared", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h00000000);
    pulses(3'h6, 5);
    `CHK_EQ("irq masked", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h00000001);
    tick(1);
    `CHK_EQ("irq unmasked", 1'b1, irq)
    wr(OFF_IRQ_STAT, 32'h00000003);
  endtask

  task automatic t_period();
    wr(OFF_CTL1, 32'h00000000);
    start_timer(3'h4, 3'h1);
    wr(OFF_IRQ_STAT, 32'h00000003);
    pulses(3'h4, 127);
    rd_cnt();
    `CHK_EQ("A match no clear", 10'h07F, cv)
    rd(OFF_IRQ_STAT);
    `CHK_EQ("A only status", 32'h00000001, rv)
    pulses(3'h4, 1);
    rd_cnt();
    `CHK_EQ("cleared at 128", 10'h000, cv)
    rd(OFF_IRQ_STAT);
    `CHK_EQ("P status", 32'h00000003, rv)
    start_timer(3'h4, 3'h0);
    wr(OFF_IRQ_STAT, 32'h00000003);
    pulses(3'h4, 1023);
    rd_cnt();
    `CHK_EQ("count at top", 10'h3FF, cv)
    pulses(3'h4, 1);
    rd_cnt();
    `CHK_EQ("overflow clear", 10'h000, cv)
    rd(OFF_IRQ_STAT);
    `CHK_EQ("overflow status", 1'b1, rv[IRQ_MATCH_P_BIT])
  endtask

  task automatic tally_and_finish();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    tick(6);
    aresetn <= 1'b1;
    tick(2);
    t_reset_and_route();
    t_cmp_buffer();
    t_sources();
    t_pause_on();
    t_match_a();
    t_period();
    tally_and_finish();
  end

  // Whole run needs well under ten thousand cycles
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_ctm_core
